// ### rtl/tcg_timer.sv
// Purpose: 16-bit up timer with capture-restart, compare, gated and capture/compare modes
// Assumes: Timer input pin is synchronous to aclk; software reaches registers over AXI4-Lite
// Notes: Byte registers sit in the low bits of each word; upper bits read as zero
`timescale 1ns/1ps
module tcg_timer
  import tcg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer pins
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_oe,
  // Timer event
  output logic timer_irq
);

  // Bus slave state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic aw_have_reg, w_have_reg, strb0_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;

  // Timer state
  tcg_ctl_type ctl_reg;
  tcg_state_type state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] reload_reg;
  logic [15:0] capture_reg;
  logic [7:0] reload_hi_tmp_reg;
  logic [7:0] hold_lo_reg;
  logic capture_cause_reg;
  logic level_prev_reg;
  logic tout_reg, tout_oe_reg, irq_reg;

  // Bus decode
  wire logic aw_fire = s_axi_awvalid && awready_reg;
  wire logic w_fire = s_axi_wvalid && wready_reg;
  wire logic ar_fire = s_axi_arvalid && arready_reg;
  wire logic wr_do = aw_have_reg && w_have_reg && !bvalid_reg;
  wire logic wr_ok = tcg_mapped(aw_addr_reg);
  wire logic [3:0] wr_idx = tcg_word_index(aw_addr_reg);
  wire logic wr_en = wr_do && wr_ok && strb0_reg;
  wire logic rd_ok = tcg_mapped(s_axi_araddr);
  wire logic [3:0] rd_idx = tcg_word_index(s_axi_araddr);
  wire logic wr_cnt_hi = wr_en && (wr_idx == IDX_COUNT_HI);
  wire logic wr_cnt_lo = wr_en && (wr_idx == IDX_COUNT_LO);
  wire logic wr_cnt = wr_cnt_hi || wr_cnt_lo;

  // Mode decode
  wire logic enabled = ctl_reg.enable;
  wire logic m_cmp = (ctl_reg.mode == MODE_COMPARE);
  wire logic m_gated = (ctl_reg.mode == MODE_GATED);
  wire logic m_capcmp = (ctl_reg.mode == MODE_CAPCMP);
  wire logic m_capres = (ctl_reg.mode == MODE_CAPRESTART);
  wire logic running = (state_reg == ST_RUN);

  // pin is input unless dual PWM
  wire logic pin_level = timer_in && ctl_reg.in_alt && (ctl_reg.mode != MODE_PWM_DUAL);
  wire logic level_act = ctl_reg.polarity ? pin_level : !pin_level;
  wire logic in_edge = level_act && !level_prev_reg;
  wire logic in_deassert = !level_act && level_prev_reg;

  // Prescaler tick, counts only in the run state
  wire logic tick;
  tcg_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(running),
    .prescale(ctl_reg.prescale),
    .tick(tick)
  );

  wire logic advance = tick && (!m_gated || level_act);
  wire logic at_reload = (count_reg == reload_reg);
  wire logic cap_ev = running && in_edge && (m_capres || m_capcmp);
  wire logic reload_ev = running && advance && at_reload && !cap_ev && (m_capres || m_gated || m_capcmp);
  wire logic cmp_ev = running && advance && at_reload && m_cmp;
  wire logic deassert_ev = running && m_gated && in_deassert;
  wire logic first_edge = (state_reg == ST_WAIT) && in_edge;

  // cause select gates the two event classes outside compare mode
  wire logic input_ev = cap_ev || deassert_ev;
  wire logic allow_input = (ctl_reg.icsel != ICSEL_RELOAD_ONLY) || m_cmp;
  wire logic allow_reload = (ctl_reg.icsel != ICSEL_INPUT_ONLY) || m_cmp;
  wire logic irq_next = (input_ev && allow_input) || ((reload_ev || cmp_ev) && allow_reload);

  // every capture, reload or compare match flips the output
  wire logic tout_flip = cap_ev || reload_ev || cmp_ev;

  // Read mux; side effects are applied in the clocked process
  // disabled low read is live
  wire logic [7:0] rd_byte =
    (rd_idx == IDX_COUNT_HI) ? count_reg[15:8] :
    (rd_idx == IDX_COUNT_LO) ? (enabled ? hold_lo_reg : count_reg[7:0]) :
    (rd_idx == IDX_RELOAD_HI) ? reload_reg[15:8] :
    (rd_idx == IDX_RELOAD_LO) ? reload_reg[7:0] :
    (rd_idx == IDX_CAPTURE_HI) ? capture_reg[15:8] :
    (rd_idx == IDX_CAPTURE_LO) ? capture_reg[7:0] :
    (rd_idx == IDX_CTL_FIRST) ? {ctl_reg.enable, ctl_reg.polarity, ctl_reg.prescale, ctl_reg.mode[2:0]} :
    (rd_idx == IDX_CTL_SECOND) ? {ctl_reg.mode[3], ctl_reg.icsel, 4'h0, capture_cause_reg} :
    {6'h00, ctl_reg.in_alt, ctl_reg.out_alt};

  // Run state: capture/compare waits for its first edge
  always_comb begin
    state_next = state_reg;
    if (!enabled) begin
      state_next = ST_OFF;
    end else if (state_reg == ST_OFF) begin
      state_next = m_capcmp ? ST_WAIT : ST_RUN;
    end else if (first_edge) begin
      state_next = ST_RUN;
    end
  end

  // Counter next value, byte writes take priority
  always_comb begin
    count_next = count_reg;
    if (wr_cnt_hi) begin
      count_next[15:8] = w_data_reg;
    end else if (wr_cnt_lo) begin
      count_next[7:0] = w_data_reg;
    end else if (cap_ev || reload_ev) begin
      count_next = COUNT_RESTART;
    end else if (running && advance) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // Write address and data slots, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      strb0_reg <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_axi_wdata[7:0];
        strb0_reg <= s_axi_wstrb[0];
      end
      aw_have_reg <= (aw_have_reg || aw_fire) && !wr_do;
      w_have_reg <= (w_have_reg || w_fire) && !wr_do;
      awready_reg <= !((aw_have_reg || aw_fire) && !wr_do);
      wready_reg <= !((w_have_reg || w_fire) && !wr_do);
    end
  end

  // Write response, unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ok ? {24'h000000, rd_byte} : '0;
      rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // high read latches the low byte while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_lo_reg <= COUNT_RST[7:0];
    end else if (ar_fire && rd_ok && enabled && (rd_idx == IDX_COUNT_HI)) begin
      hold_lo_reg <= count_reg[7:0];
    end
  end

  // Control, pin configuration and reload registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= CTL_RST;
      reload_reg <= RELOAD_RST;
      reload_hi_tmp_reg <= RELOAD_RST[15:8];
    end else if (wr_en) begin
      if (wr_idx == IDX_CTL_FIRST) begin
        ctl_reg.enable <= w_data_reg[F1_ENABLE];
        ctl_reg.polarity <= w_data_reg[F1_POLARITY];
        ctl_reg.prescale <= w_data_reg[F1_PRESCALE_LSB +: 3];
        ctl_reg.mode[2:0] <= w_data_reg[F1_MODE_LSB +: 3];
      end else if (wr_idx == IDX_CTL_SECOND) begin
        ctl_reg.mode[3] <= w_data_reg[F2_MODE_EXT];
        ctl_reg.icsel <= w_data_reg[F2_ICSEL_LSB +: 2];
      end else if (wr_idx == IDX_PIN_CFG) begin
        ctl_reg.out_alt <= w_data_reg[FP_OUT_ALT];
        ctl_reg.in_alt <= w_data_reg[FP_IN_ALT];
      end else if (wr_idx == IDX_RELOAD_HI) begin
        // high byte waits in the holding register
        reload_hi_tmp_reg <= w_data_reg;
      end else if (wr_idx == IDX_RELOAD_LO) begin
        reload_reg <= {reload_hi_tmp_reg, w_data_reg};
      end
    end
  end

  // Counter, run state and input history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= COUNT_RST;
      state_reg <= ST_OFF;
      level_prev_reg <= 1'b1; // Matches the idle sense, so reset shows no edge
    end else begin
      count_reg <= count_next;
      state_reg <= state_next;
      level_prev_reg <= level_act;
    end
  end

  // capture wins over a software write to the pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reg <= CAPTURE_RST;
    end else if (cap_ev) begin
      capture_reg <= count_reg;
    end else if (wr_en && (wr_idx == IDX_CAPTURE_HI)) begin
      capture_reg[15:8] <= w_data_reg;
    end else if (wr_en && (wr_idx == IDX_CAPTURE_LO)) begin
      capture_reg[7:0] <= w_data_reg;
    end
  end

  // hardware set and clear beat a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_cause_reg <= 1'b0;
    end else if (cap_ev) begin
      capture_cause_reg <= 1'b1;
    end else if (reload_ev && !m_gated) begin
      capture_cause_reg <= 1'b0;
    end else if (wr_en && (wr_idx == IDX_CTL_SECOND)) begin
      capture_cause_reg <= w_data_reg[F2_CAPTURE_CAUSE];
    end
  end

  // output parks at the polarity level while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tout_reg <= 1'b0;
      tout_oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      tout_oe_reg <= ctl_reg.out_alt;
      irq_reg <= irq_next;
      if (!enabled) begin
        tout_reg <= ctl_reg.polarity;
      end else if (tout_flip && ctl_reg.out_alt) begin
        tout_reg <= !tout_reg;
      end
    end
  end

  // Registered outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_out = tout_reg;
  assign timer_out_oe = tout_oe_reg;
  assign timer_irq = irq_reg;

  // Capture restarts the count and holds the old value
  property p_capture_restart;
    @(posedge aclk) disable iff (!aresetn)
    (cap_ev && !wr_cnt) |=> (count_reg == 16'h0001) && (capture_reg == $past(count_reg));
  endproperty
  a_capture_restart: assert property (p_capture_restart) else $error("capture did not restart count");

  // Capture sets the cause flag and raises the event when allowed
  property p_capture_flag;
    @(posedge aclk) disable iff (!aresetn)
    (cap_ev && ctl_reg.icsel != ICSEL_RELOAD_ONLY) |=> capture_cause_reg && timer_irq;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture flag or event missing");

  // Reload returns the count to 0001h
  property p_reload_restart;
    @(posedge aclk) disable iff (!aresetn)
    (reload_ev && !wr_cnt) |=> count_reg == 16'h0001;
  endproperty
  a_reload_restart: assert property (p_reload_restart) else $error("reload did not restart count");

  // Compare match keeps counting upward
  property p_compare_continue;
    @(posedge aclk) disable iff (!aresetn)
    (cmp_ev && !wr_cnt) |=> (count_reg == 16'($past(count_reg) + 16'h0001)) && timer_irq;
  endproperty
  a_compare_continue: assert property (p_compare_continue) else $error("compare match restarted count");

  // Compare match flips the output pin
  property p_compare_toggle;
    @(posedge aclk) disable iff (!aresetn)
    (cmp_ev && ctl_reg.out_alt) |=> timer_out != $past(timer_out);
  endproperty
  a_compare_toggle: assert property (p_compare_toggle) else $error("output not toggled on match");

  // Gated count holds while input inactive
  property p_gated_hold;
    @(posedge aclk) disable iff (!aresetn)
    (m_gated && !level_act && !wr_cnt) |=> $stable(count_reg);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated count moved while inactive");

  // Waiting for the first edge raises nothing
  property p_wait_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_WAIT) ##1 (state_reg == ST_RUN) |-> !timer_irq ##1 !timer_irq;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("first edge raised an event");

  // Disabled output follows the polarity level
  property p_idle_level;
    @(posedge aclk) disable iff (!aresetn)
    !enabled |=> timer_out == $past(ctl_reg.polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle output level wrong");

endmodule : tcg_timer

// ### rtl/tcg_pkg.sv
// Purpose: Shared constants and types for the capture/compare/gated timer
// Assumes: AXI4-Lite register access, 32-bit data, one byte register per word
// Notes: Byte address of a register is four times its index
package tcg_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices (byte address = index * 4)
  localparam logic [3:0] IDX_COUNT_HI = 4'h0;
  localparam logic [3:0] IDX_COUNT_LO = 4'h1;
  localparam logic [3:0] IDX_RELOAD_HI = 4'h2;
  localparam logic [3:0] IDX_RELOAD_LO = 4'h3;
  localparam logic [3:0] IDX_CAPTURE_HI = 4'h4;
  localparam logic [3:0] IDX_CAPTURE_LO = 4'h5;
  localparam logic [3:0] IDX_CTL_FIRST = 4'h6;
  localparam logic [3:0] IDX_CTL_SECOND = 4'h7;
  localparam logic [3:0] IDX_PIN_CFG = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'h8;

  // Field positions in timer_control_first
  localparam int F1_ENABLE = 7;
  localparam int F1_POLARITY = 6;
  localparam int F1_PRESCALE_LSB = 3;
  localparam int F1_MODE_LSB = 0;
  // Field positions in timer_control_second
  localparam int F2_MODE_EXT = 7;
  localparam int F2_ICSEL_LSB = 5;
  localparam int F2_CAPTURE_CAUSE = 0;
  // Field positions in the pin configuration register
  localparam int FP_OUT_ALT = 0;
  localparam int FP_IN_ALT = 1;

  // Reset and restart values
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [6:0] PRESCALE_CNT_RST = 7'h00;

  // Interrupt cause selections
  localparam logic [1:0] ICSEL_INPUT_ONLY = 2'h2;
  localparam logic [1:0] ICSEL_RELOAD_ONLY = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Modes, as {mode_extension_bit, mode field}
  typedef enum logic [3:0] {
    MODE_COMPARE = 4'h2,
    MODE_GATED = 4'h6,
    MODE_CAPCMP = 4'h7,
    MODE_PWM_DUAL = 4'hc,
    MODE_CAPRESTART = 4'he
  } tcg_mode_type;

  // Run state, Gray coded along off -> wait -> run
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } tcg_state_type;

  // Control fields travelling together
  typedef struct packed {
    logic enable;
    logic polarity;
    logic [2:0] prescale;
    logic [3:0] mode;
    logic [1:0] icsel;
    logic out_alt;
    logic in_alt;
  } tcg_ctl_type;

  localparam tcg_ctl_type CTL_RST = '{default: '0};

  // Word index of a byte address
  function automatic logic [3:0] tcg_word_index(input logic [ADDR_W-1:0] addr);
    tcg_word_index = addr[5:2];
  endfunction : tcg_word_index

  // Address maps onto a register
  function automatic logic tcg_mapped(input logic [ADDR_W-1:0] addr);
    tcg_mapped = (addr[ADDR_W-1:6] == '0) && (addr[5:2] <= IDX_LAST);
  endfunction : tcg_mapped

endpackage : tcg_pkg

// ### rtl/tcg_prescaler.sv
// Purpose: Divides the system clock into counter advance ticks
// Assumes: Prescale code n divides by 2 to the power n (1 to 128)
// Notes: Divider restarts whenever the timer is stopped
`timescale 1ns/1ps
module tcg_prescaler
  import tcg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [2:0] prescale,
  // Advance pulse
  output logic tick
);

  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic tick_reg;
  logic tick_next;
  wire logic [6:0] div_limit;

  // Terminal count for the selected division
  assign div_limit = 7'((8'h01 << prescale) - 8'h01);

  always_comb begin
    div_next = div_reg + 7'h01;
    tick_next = 1'b0;
    if (!run) begin
      div_next = PRESCALE_CNT_RST;
    end else if (div_reg >= div_limit) begin
      div_next = PRESCALE_CNT_RST;
      tick_next = 1'b1;
    end
  end

  // Divider state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= PRESCALE_CNT_RST;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : tcg_prescaler

// ### bench/tcg_in_model.sv
// Purpose: Outside digital source on the timer input pin
// Assumes: Source is synchronous to aclk, as the timer expects
// Notes: DLY sets how many cycles the pin lags the command
`timescale 1ns/1ps
module tcg_in_model #(
  parameter int DLY = 2
) (
  // Clock
  input wire logic aclk,
  // Command and pin
  input wire logic level_cmd,
  output logic timer_in
);
  logic [7:0] pipe_reg = 8'h00;

  // Delay line: a slow source shows its new level late
  always @(posedge aclk) begin
    pipe_reg <= {pipe_reg[6:0], level_cmd};
  end
  assign timer_in = pipe_reg[DLY-1];
endmodule : tcg_in_model

// ### bench/tb_timer_capture_compare_gated_modes.sv
// Purpose: Self-checking bench for the capture/compare/gated timer
// Assumes: AXI4-Lite master in the bench, input pin from the source model
// Notes: Random waits come from a fixed-seed shift register
`timescale 1ns/1ps
module tb_timer_capture_compare_gated_modes
  import tcg_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, lvl = 1'b0;
  logic awr, wrdy, bv, arr, rv, tin, tout, toe, irq;
  logic [1:0] bresp, rresp;
  int miscompares = 0, n_checks = 0, cyc = 0;

  // Clock of 25 ns
  always #12.5 aclk = ~aclk;

  tcg_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .timer_in(tin),
    .timer_out(tout), .timer_out_oe(toe), .timer_irq(irq));
  tcg_in_model src (.aclk(aclk), .level_cmd(lvl), .timer_in(tin));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [7:0] ba(input logic [3:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ba

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask : ok

  // Write one byte register; each channel held until its own ready
  task automatic wreg(input logic [3:0] i, input logic [7:0] d);
    logic done;
    done = 1'b0;
    awaddr <= ba(i);
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) begin
        done = 1'b1;
        br <= 1'b0;
      end
    end
    // Let one edge pass so a following call never reassigns a strobe in this step
    @(posedge aclk);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rr <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask : rreg

  // High byte first, so an enabled count reads through the latch
  task automatic rd16(input logic [3:0] i, output logic [15:0] v);
    logic [31:0] h, l;
    logic [1:0] r;
    rreg(ba(i), h, r);
    rreg(ba(i + 4'h1), l, r);
    v = {h[7:0], l[7:0]};
  endtask : rd16

  task automatic wirq(input int n, output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (irq !== 1'b1 && k < n);
    ok(irq === 1'b1);
  endtask : wirq

  // Count event pulses over a window in which none may come
  task automatic quiet(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge aclk);
      if (irq === 1'b1) k++;
    end
  endtask : quiet

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Hang guard, well above the longest reload wait
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d, seed;
    logic [1:0] r;
    logic [15:0] v;
    logic pol;
    int k, n;
    seed = 32'hdc857a67;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rreg(ba(IDX_COUNT_LO), d, r);
    chk(d, 32'h01);
    rreg(8'h40, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wreg(IDX_RELOAD_HI, 8'h00);
    rreg(ba(IDX_RELOAD_HI), d, r);
    chk(d, 32'hff);
    wreg(IDX_RELOAD_LO, 8'h02);
    rd16(IDX_RELOAD_HI, v);
    chk({16'h0, v}, 32'h0002);
    $display("test reset and reload pair done");
    // Compare: start near the top, match only after the wrap
    wreg(IDX_COUNT_HI, 8'hff);
    wreg(IDX_COUNT_LO, 8'hfe);
    wreg(IDX_PIN_CFG, 8'h01);
    wreg(IDX_CTL_FIRST, 8'h42);
    ok(tout === 1'b1 && toe === 1'b1);
    wreg(IDX_CTL_FIRST, 8'hc2);
    wirq(20, k);
    ok(tout === 1'b0);
    repeat (6) @(posedge aclk);
    wreg(IDX_CTL_FIRST, 8'h42);
    rd16(IDX_COUNT_HI, v);
    ok(v > 16'h0003 && v < 16'h0040);
    $display("test compare done");
    // Capture-restart with both polarities and a random delay
    for (int p = 0; p < 2; p++) begin
      seed = lfsr(seed);
      pol = p[0];
      lvl <= ~pol;
      wreg(IDX_CTL_FIRST, {1'b0, pol, 6'h06});
      wreg(IDX_CTL_SECOND, 8'h80);
      wreg(IDX_RELOAD_HI, 8'h0f);
      wreg(IDX_RELOAD_LO, 8'hff);
      wreg(IDX_COUNT_HI, 8'h00);
      wreg(IDX_COUNT_LO, 8'h01);
      wreg(IDX_CAPTURE_HI, 8'h00);
      wreg(IDX_CAPTURE_LO, 8'h00);
      wreg(IDX_PIN_CFG, 8'h03);
      wreg(IDX_CTL_FIRST, {1'b1, pol, 6'h06});
      repeat (16 + int'(seed[5:0])) @(posedge aclk);
      lvl <= pol;
      wirq(8, k);
      lvl <= ~pol;
      rd16(IDX_CAPTURE_HI, v);
      ok(v > 16'h000f && v < 16'h0090);
      rreg(ba(IDX_CTL_SECOND), d, r);
      chk(d, 32'h81);
      wirq(4200, k);
      ok(k > 3900);
      rreg(ba(IDX_CTL_SECOND), d, r);
      chk(d, 32'h80);
      wreg(IDX_CTL_FIRST, 8'h00);
    end
    $display("test capture restart done");
    // Gated: count holds while inactive, first pass from start value
    lvl <= 1'b0;
    wreg(IDX_CTL_SECOND, 8'h00);
    wreg(IDX_CTL_FIRST, 8'h46);
    wreg(IDX_RELOAD_HI, 8'h00);
    wreg(IDX_RELOAD_LO, 8'h20);
    wreg(IDX_COUNT_LO, 8'h10);
    wreg(IDX_CTL_FIRST, 8'hc6);
    repeat (30) @(posedge aclk);
    rd16(IDX_COUNT_HI, v);
    chk({16'h0, v}, 32'h0010);
    pol = tout;
    lvl <= 1'b1;
    wirq(40, k);
    ok(tout === ~pol);
    wirq(60, k);
    ok(k > 27);
    lvl <= 1'b0;
    wirq(8, k);
    $display("test gated done");
    // Capture/compare: idle until the first edge, then capture and compare restarts
    seed = lfsr(seed);
    n = 16 + int'(seed[4:0]);
    wreg(IDX_CTL_FIRST, 8'h47);
    wreg(IDX_CTL_SECOND, 8'h00);
    wreg(IDX_RELOAD_HI, 8'h00);
    wreg(IDX_RELOAD_LO, {2'h2, seed[10:5]});
    wreg(IDX_COUNT_HI, 8'h00);
    wreg(IDX_COUNT_LO, 8'h01);
    wreg(IDX_CTL_FIRST, 8'hc7);
    repeat (20) @(posedge aclk);
    rd16(IDX_COUNT_HI, v);
    chk({16'h0, v}, 32'h0001);
    lvl <= 1'b1;
    quiet(12, k);
    chk(k, 0);
    lvl <= 1'b0;
    repeat (n) @(posedge aclk);
    lvl <= 1'b1;
    wirq(8, k);
    rd16(IDX_CAPTURE_HI, v);
    ok(int'(v) > n + 8 && int'(v) < n + 14);
    wirq(300, k);
    ok(k > 100);
    rreg(ba(IDX_CTL_SECOND), d, r);
    chk(d, 32'h00);
    // Input-only cause select hides reloads but keeps captures
    wreg(IDX_CTL_FIRST, 8'h47);
    wreg(IDX_CTL_SECOND, 8'h40);
    lvl <= 1'b0;
    wreg(IDX_CTL_FIRST, 8'hc7);
    lvl <= 1'b1;
    quiet(400, k);
    chk(k, 0);
    rd16(IDX_COUNT_HI, v);
    ok(v < 16'h00c0);
    lvl <= 1'b0;
    repeat (4) @(posedge aclk);
    lvl <= 1'b1;
    wirq(8, k);
    rreg(ba(IDX_CTL_SECOND), d, r);
    chk(d, 32'h41);
    wreg(IDX_CTL_FIRST, 8'h00);
    $display("test capture compare done");
    close_out();
  end
endmodule : tb_timer_capture_compare_gated_modes
